// file: rtl/asc_pkg.sv
// Package: offsets, fields, reset values and timing of the converter control block.
// Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
package asc_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [3:0] OFF_CTRL0 = 4'h0;
  localparam logic [3:0] OFF_CTRL1 = 4'h4;
  localparam logic [3:0] OFF_CTRL2 = 4'h8;
  localparam logic [3:0] OFF_RES_HI = 4'hC;
  localparam logic [4:0] OFF_RES_LO = 5'h10;
  localparam logic [4:0] OFF_STATUS = 5'h14;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CAL_BIT = 7;
  localparam int CHS_LSB = 2;
  localparam int GO_BIT = 1;
  localparam int EN_BIT = 0;
  localparam int TRIG_BIT = 7;
  localparam int NREF_BIT = 5;
  localparam int PREF_BIT = 4;
  localparam int FM_BIT = 7;
  localparam int ACQ_LSB = 3;
  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] CTRL0_MASK = 8'hBF;
  localparam logic [7:0] CTRL1_MASK = 8'hBF;
  localparam logic [7:0] CTRL2_MASK = 8'hBF;
  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_HZ = 20000000;
  localparam int RC_TAD_NS = 4000;
  localparam int RC_TAD_CYC = (RC_TAD_NS * (SYS_CLK_HZ / 1000000)) / 1000;
  localparam int TCY_OSC = 4;
  localparam logic [4:0] CONV_TAD = 5'h0B;
  localparam logic [4:0] WAIT_TAD = 5'h02;
  localparam int CH_COUNT = 12;
  localparam int RES_W = 10;
  localparam logic [7:0] RC_TAD_M1 = 8'(RC_TAD_CYC - 1);
  localparam logic [7:0] TCY_M1 = 8'(TCY_OSC - 1);

  typedef enum logic [2:0] {ASC_IDLE, ASC_DELAY, ASC_ACQ, ASC_CONV, ASC_WAIT} asc_state_t;
endpackage

// file: rtl/asc_tad_if.sv
// Interface: conversion clock tick carrier between sequencer and divider.
// Assumes a single clock domain.
`timescale 1ns/1ps
interface asc_tad_if;
  logic run;
  logic [2:0] sel;
  logic tick;
  modport ctl (output run, output sel, input tick);
  modport gen (input run, input sel, output tick);
endinterface

// file: rtl/asc_tad_gen.sv
// Conversion clock tick generator: oscillator divider or internal RC period.
// Assumes run is held high through the acquisition, conversion and wait phases of a sequence.
`timescale 1ns/1ps
module asc_tad_gen (
  input wire logic clk,
  input wire logic resetn,
  asc_tad_if.gen tif
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] lim;
  logic hit;

  // ****************************************
  // Divider limit from clock select
  // ****************************************
  function automatic logic [7:0] div_m1(input logic [2:0] s);
    logic [7:0] r;
    r = 8'h00;
    unique case (s)
      3'h0: r = 8'h01;
      3'h1: r = 8'h07;
      3'h2: r = 8'h1F;
      3'h4: r = 8'h03;
      3'h5: r = 8'h0F;
      3'h6: r = 8'h3F;
      default: r = asc_pkg::RC_TAD_M1;
    endcase
    return r;
  endfunction

  assign lim = div_m1(tif.sel);
  assign hit = tif.run && (cnt_q >= lim);
  assign cnt_d = (!tif.run || hit) ? 8'h00 : cnt_q + 8'h01;
  assign tif.tick = hit;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// file: rtl/asc_top.sv
// Top: converter control registers, sequencer and Avalon-MM slave.
// Assumes triggers are synchronous pulses and the analog core is modelled by the sample input.
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module asc_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ctu_trigger,
  input wire logic capture_compare_two_trigger,
  input wire logic sleep_mode,
  input wire logic [9:0] sample_code,
  output logic [3:0] channel_select,
  output logic [11:0] pin_analog_mask,
  output logic neg_reference_select,
  output logic pos_reference_select,
  output logic converter_enable,
  output logic sample_hold,
  output logic calibrate_active,
  output logic conversion_done_flag
);
  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [7:0] res_hi_q;
  logic [7:0] res_lo_q;
  logic flag_q;
  logic cal_pend_q;
  logic cal_run_q;
  logic [1:0] ack_q;
  logic [9:0] sar_q;
  logic [4:0] tad_cnt_q;
  logic [4:0] tad_cnt_d;
  asc_pkg::asc_state_t st_q;
  asc_pkg::asc_state_t st_d;
  logic [1:0] trg_s1_q;
  logic [1:0] trg_s2_q;
  logic [9:0] code_s1_q;
  logic [9:0] code_s2_q;

  asc_tad_if tif ();

  asc_tad_gen u_tad (
    .clk(clk),
    .resetn(resetn),
    .tif(tif)
  );

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [4:0] acq_tad(input logic [2:0] c);
    logic [4:0] r;
    r = 5'h00;
    unique case (c)
      3'h0: r = 5'h00;
      3'h1: r = 5'h02;
      3'h2: r = 5'h04;
      3'h3: r = 5'h06;
      3'h4: r = 5'h08;
      3'h5: r = 5'h0C;
      3'h6: r = 5'h10;
      3'h7: r = 5'h14;
    endcase
    return r;
  endfunction

  function automatic logic [11:0] analog_mask(input logic [3:0] p);
    logic [11:0] m;
    m = 12'hFFF;
    if (p >= 4'h4) begin
      m = 12'hFFF >> (p - 4'h3);
    end
    return m;
  endfunction

  // ****************************************
  // Decode
  // ****************************************
  wire enabled = ctrl0_q[asc_pkg::EN_BIT];
  wire go_bit = ctrl0_q[asc_pkg::GO_BIT];
  wire [2:0] acq_sel = ctrl2_q[asc_pkg::ACQ_LSB +: 3];
  wire [2:0] clk_sel = ctrl2_q[2:0];
  wire rc_sel = (clk_sel[1:0] == 2'h3);
  wire trig_sel = ctrl1_q[asc_pkg::TRIG_BIT];
  wire hw_trig = trig_sel ? trg_s2_q[1] : trg_s2_q[0];
  wire tick = tif.tick;
  wire can_run = !sleep_mode || rc_sel;
  wire wr_acc = avs_write && ack_q[0];
  wire rd_acc = avs_read && !ack_q[0];
  wire wr_c0 = wr_acc && avs_byteenable[0] && (avs_address == {1'b0, asc_pkg::OFF_CTRL0});
  wire wr_c1 = wr_acc && avs_byteenable[0] && (avs_address == {1'b0, asc_pkg::OFF_CTRL1});
  wire wr_c2 = wr_acc && avs_byteenable[0] && (avs_address == {1'b0, asc_pkg::OFF_CTRL2});
  wire wr_rh = wr_acc && avs_byteenable[0] && (avs_address == {1'b0, asc_pkg::OFF_RES_HI});
  wire wr_rl = wr_acc && avs_byteenable[0] && (avs_address == asc_pkg::OFF_RES_LO);
  wire wr_st = wr_acc && avs_byteenable[0] && (avs_address == asc_pkg::OFF_STATUS);
  wire [7:0] wdat = avs_writedata[7:0];
  wire sw_go = wr_c0 && wdat[asc_pkg::GO_BIT] && !go_bit && enabled;
  wire sw_abort = wr_c0 && (!wdat[asc_pkg::GO_BIT] || !wdat[asc_pkg::EN_BIT]) && go_bit;
  wire start = enabled && (st_q == asc_pkg::ASC_IDLE) && (sw_go || hw_trig);
  wire busy = (st_q != asc_pkg::ASC_IDLE) && (st_q != asc_pkg::ASC_WAIT);
  wire acq_zero = (acq_tad(acq_sel) == 5'h00);
  wire cal_now = wr_c0 ? wdat[asc_pkg::CAL_BIT] : ctrl0_q[asc_pkg::CAL_BIT];
  wire done = (st_q == asc_pkg::ASC_CONV) && tick && (tad_cnt_q == asc_pkg::CONV_TAD - 5'h01);
  wire [9:0] res_val = code_s2_q;
  wire [7:0] new_hi = ctrl2_q[asc_pkg::FM_BIT] ? {6'h00, res_val[9:8]} : res_val[9:2];
  wire [7:0] new_lo = ctrl2_q[asc_pkg::FM_BIT] ? res_val[7:0] : {res_val[1:0], 6'h00};

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    st_d = st_q;
    tad_cnt_d = tad_cnt_q;
    unique case (st_q)
      asc_pkg::ASC_IDLE: begin
        tad_cnt_d = 5'h00;
        if (start) begin
          st_d = rc_sel ? asc_pkg::ASC_DELAY : asc_pkg::ASC_ACQ;
        end
      end
      asc_pkg::ASC_DELAY: begin
        if (tad_cnt_q == asc_pkg::TCY_M1[4:0]) begin
          st_d = asc_pkg::ASC_ACQ;
          tad_cnt_d = 5'h00;
        end else begin
          tad_cnt_d = tad_cnt_q + 5'h01;
        end
      end
      asc_pkg::ASC_ACQ: begin
        if (acq_zero) begin
          st_d = asc_pkg::ASC_CONV;
          tad_cnt_d = 5'h00;
        end else if (tick && can_run) begin
          if (acq_tad(acq_sel) == tad_cnt_q + 5'h01) begin
            st_d = asc_pkg::ASC_CONV;
            tad_cnt_d = 5'h00;
          end else begin
            tad_cnt_d = tad_cnt_q + 5'h01;
          end
        end
      end
      asc_pkg::ASC_CONV: begin
        if (done) begin
          st_d = asc_pkg::ASC_WAIT;
          tad_cnt_d = 5'h00;
        end else if (tick && can_run) begin
          tad_cnt_d = tad_cnt_q + 5'h01;
        end
      end
      asc_pkg::ASC_WAIT: begin
        if (tick && tad_cnt_q == asc_pkg::WAIT_TAD - 5'h01) begin
          st_d = asc_pkg::ASC_IDLE;
        end else if (tick) begin
          tad_cnt_d = tad_cnt_q + 5'h01;
        end
      end
    endcase
    if (sw_abort && busy) begin
      st_d = asc_pkg::ASC_WAIT;
      tad_cnt_d = 5'h00;
    end
  end

  assign tif.run = ((st_q == asc_pkg::ASC_ACQ) && !acq_zero) || (st_q == asc_pkg::ASC_CONV)
                   || (st_q == asc_pkg::ASC_WAIT);
  assign tif.sel = clk_sel;

  // ****************************************
  // Synchronisers
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trg_s1_q <= 2'h0;
      trg_s2_q <= 2'h0;
      code_s1_q <= 10'h000;
      code_s2_q <= 10'h000;
    end else begin
      trg_s1_q <= {ctu_trigger, capture_compare_two_trigger};
      trg_s2_q <= trg_s1_q;
      code_s1_q <= sample_code;
      code_s2_q <= code_s1_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= asc_pkg::ASC_IDLE;
      tad_cnt_q <= 5'h00;
      sar_q <= 10'h000;
    end else begin
      st_q <= st_d;
      tad_cnt_q <= tad_cnt_d;
      sar_q <= (st_q == asc_pkg::ASC_CONV && tick) ? res_val : sar_q;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl0_q <= asc_pkg::CTRL0_RST;
      ctrl1_q <= asc_pkg::CTRL1_RST;
      ctrl2_q <= asc_pkg::CTRL2_RST;
    end else begin
      if (wr_c0) begin
        ctrl0_q <= (wdat & asc_pkg::CTRL0_MASK & 8'hFD) | {6'h00, sw_go, 1'b0}
                   | {6'h00, go_bit && wdat[asc_pkg::GO_BIT] && wdat[asc_pkg::EN_BIT], 1'b0};
      end else if (done) begin
        ctrl0_q <= ctrl0_q & 8'hFD;
      end else if (start) begin
        ctrl0_q <= ctrl0_q | 8'h02;
      end
      if (wr_c1) begin
        ctrl1_q <= wdat & asc_pkg::CTRL1_MASK;
      end
      if (wr_c2) begin
        ctrl2_q <= wdat & asc_pkg::CTRL2_MASK;
      end
    end
  end

  // ****************************************
  // Result pair, flag, calibration
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      res_hi_q <= 8'h00;
      res_lo_q <= 8'h00;
      flag_q <= 1'b0;
      cal_pend_q <= 1'b0;
      cal_run_q <= 1'b0;
    end else begin
      if (done) begin
        res_hi_q <= new_hi;
        res_lo_q <= new_lo;
      end else begin
        res_hi_q <= wr_rh ? wdat : res_hi_q;
        res_lo_q <= wr_rl ? wdat : res_lo_q;
      end
      flag_q <= done || (flag_q && !(wr_st && wdat[0]));
      cal_pend_q <= ctrl0_q[asc_pkg::CAL_BIT];
      if (start) begin
        cal_run_q <= cal_now;
      end else if (!busy) begin
        cal_run_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  wire [7:0] rd_mux =
    (avs_address == {1'b0, asc_pkg::OFF_CTRL0}) ? ctrl0_q :
    (avs_address == {1'b0, asc_pkg::OFF_CTRL1}) ? ctrl1_q :
    (avs_address == {1'b0, asc_pkg::OFF_CTRL2}) ? ctrl2_q :
    (avs_address == {1'b0, asc_pkg::OFF_RES_HI}) ? res_hi_q :
    (avs_address == asc_pkg::OFF_RES_LO) ? res_lo_q :
    (avs_address == asc_pkg::OFF_STATUS) ? {5'h00, cal_pend_q, busy, flag_q} : 8'h00;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 2'h0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_q <= {1'b0, (avs_read || avs_write) && !ack_q[0]};
      if (rd_acc) begin
        avs_readdata <= {24'h000000, rd_mux};
      end
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_q[0];

  assign channel_select = ctrl0_q[asc_pkg::CHS_LSB +: 4];
  assign pin_analog_mask = analog_mask(ctrl1_q[3:0]);
  assign neg_reference_select = ctrl1_q[asc_pkg::NREF_BIT];
  assign pos_reference_select = ctrl1_q[asc_pkg::PREF_BIT];
  assign converter_enable = enabled;
  assign sample_hold = (st_q == asc_pkg::ASC_CONV);
  assign calibrate_active = cal_run_q;
  assign conversion_done_flag = flag_q;
endmodule

// file: testbench/asc_top_checker.sv
// Checker: bus, decode and sequencing assertions on the converter control top ports.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module asc_top_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [11:0] pin_analog_mask,
  input wire logic converter_enable,
  input wire logic sample_hold,
  input wire logic calibrate_active,
  input wire logic conversion_done_flag
);
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  wait_state_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer missing after one wait state");
  read_width_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  reset_state_a: assert property ($rose(resetn) |-> pin_analog_mask == 12'hFFF && !converter_enable && !sample_hold)
    else $error("outputs not at reset state");
  mask_shape_a: assert property (((pin_analog_mask + 12'h001) & pin_analog_mask) == 12'h000)
    else $error("analog pin mask not contiguous from channel zero");
  conv_len_a: assert property ($rose(sample_hold) |=> sample_hold [*8])
    else $error("conversion phase too short");
  conv_end_a: assert property ($rose(sample_hold) |-> ##[1:1000] !sample_hold)
    else $error("conversion phase never ends");
  post_wait_a: assert property ($fell(sample_hold) |-> !sample_hold [*4])
    else $error("no wait after conversion");
  done_cause_a: assert property ($rose(conversion_done_flag) |-> $past(sample_hold) || $past(sample_hold, 2))
    else $error("done flag without conversion");
  flag_sticky_a: assert property (conversion_done_flag && !(avs_write && avs_address == asc_pkg::OFF_STATUS)
    |=> conversion_done_flag)
    else $error("done flag lost without clear");
  enable_gate_a: assert property ($rose(sample_hold) |-> converter_enable)
    else $error("conversion while disabled");
  off_idle_a: assert property (!converter_enable && !$past(converter_enable) |-> !sample_hold)
    else $error("disabled converter still converting");
  cover property ($fell(sample_hold));
  cover property ($rose(conversion_done_flag));
  cover property (calibrate_active);
  cover property (pin_analog_mask == 12'h000);
endmodule

bind asc_top asc_top_checker i_asc_top_checker (
  .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_analog_mask(pin_analog_mask),
  .converter_enable(converter_enable), .sample_hold(sample_hold), .calibrate_active(calibrate_active),
  .conversion_done_flag(conversion_done_flag)
);

// file: testbench/asc_top_tb.sv
// Testbench: register access, pin decode, conversion timing, triggers, sleep, abort and reset.
// Assumes the bench alone drives the top ports; byte lanes are always all enabled.
`timescale 1ns/1ps
module asc_top_tb;
  localparam logic [4:0] A0 = 5'(asc_pkg::OFF_CTRL0);
  localparam logic [4:0] A1 = 5'(asc_pkg::OFF_CTRL1);
  localparam logic [4:0] A2 = 5'(asc_pkg::OFF_CTRL2);
  localparam logic [4:0] AH = 5'(asc_pkg::OFF_RES_HI);
  localparam logic [4:0] AL = asc_pkg::OFF_RES_LO;
  localparam logic [4:0] AS = asc_pkg::OFF_STATUS;
  logic clk, resetn, avs_read, avs_write, ctu_t, ccp_t, sleep_m, seen_cal;
  logic wreq, nref, pref, cen, sh, cal_act, dflag;
  logic [4:0] adr;
  logic [31:0] wd, rdat, rs;
  logic [9:0] smp;
  logic [3:0] chs;
  logic [11:0] pmask;
  logic [7:0] q;
  logic [15:0] last;
  int n_errors, checks, cyc, sh_len;
  asc_top i_asc_top (
    .clk(clk), .resetn(resetn), .avs_address(adr), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .ctu_trigger(ctu_t), .capture_compare_two_trigger(ccp_t), .sleep_mode(sleep_m), .sample_code(smp),
    .channel_select(chs), .pin_analog_mask(pmask), .neg_reference_select(nref),
    .pos_reference_select(pref), .converter_enable(cen), .sample_hold(sh),
    .calibrate_active(cal_act), .conversion_done_flag(dflag)
  );
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int acq_tad(input logic [2:0] c);
    int t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    return t[c];
  endfunction
  function automatic int tad_clk(input logic [2:0] c);
    return (c[1:0] == 2'h3) ? asc_pkg::RC_TAD_CYC : ((c[2] ? 4 : 2) << (2 * c[1:0]));
  endfunction
  function automatic logic [15:0] res_exp(input logic [9:0] v, input logic fm);
    return fm ? {6'h00, v} : {v, 6'h00};
  endfunction
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic ok(input logic c);
    chk(16'(c), 16'h0001);
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= {24'h000000, d};
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(negedge clk);
      n++;
      if (wreq !== 1'b0) @(posedge clk);
    end while (wreq !== 1'b0 && n < 100);
    @(posedge clk);
    q = rdat[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge clk);
    ok(n < 100);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(16'(q), 16'(e));
  endtask
  task automatic fire(input logic s);
    @(posedge clk);
    ctu_t <= s;
    ccp_t <= !s;
    @(posedge clk);
    ctu_t <= 1'b0;
    ccp_t <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic conv(input logic [3:0] ch, input logic [2:0] aq, input logic [2:0] cs, input logic fm,
                      input logic cal);
    int t0, lim, tad;
    logic [15:0] ex;
    tad = tad_clk(cs);
    lim = (acq_tad(aq) + 11) * tad + ((cs[1:0] == 2'h3) ? asc_pkg::TCY_OSC : 0);
    rs = lfsr(rs);
    smp <= rs[9:0];
    ex = res_exp(rs[9:0], fm);
    wr(A2, {fm, 1'b0, aq, cs});
    wr(A0, {2'h0, ch, 2'h1});
    chk(16'(chs), 16'(ch));
    seen_cal <= 1'b0;
    sh_len <= 0;
    wr(A0, {cal, 1'b0, ch, 2'h3});
    t0 = cyc;
    q = 8'h02;
    while (q[1] === 1'b1 && cyc - t0 < 5000) begin
      bus(1'b0, A0, 8'h00);
    end
    ok(cyc - t0 >= lim && cyc - t0 <= lim + tad + 16);
    chk(16'(sh_len), 16'(11 * tad));
    rdc(AH, ex[15:8]);
    rdc(AL, ex[7:0]);
    ok(dflag === 1'b1 && seen_cal === cal);
    wr(AS, 8'h01);
    rdc(AS, {5'h00, cal, 2'h0});
    last = ex;
    repeat (2 * tad + 4) @(posedge clk);
  endtask
  // ****
  // Clock, monitor and sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cal_act === 1'b1) seen_cal <= 1'b1;
    if (sh === 1'b1) sh_len <= sh_len + 1;
    if (cyc == 60000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    logic [4:0] am [6] = '{A0, A1, A2, AH, AL, AS};
    resetn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    adr = 5'h00;
    wd = 32'h00000000;
    ctu_t = 1'b0;
    ccp_t = 1'b0;
    sleep_m = 1'b0;
    smp = 10'h000;
    rs = 32'h1FEA4F4A;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    foreach (am[i]) rdc(am[i], 8'h00);
    ok(pmask === 12'hFFF && cen === 1'b0);
    wr(5'h18, 8'hFF);
    rdc(5'h18, 8'h00);
    wr(A0, 8'h3D);
    rdc(A0, 8'h3D);
    ok(cen === 1'b1 && chs === 4'hF);
    wr(A0, 8'h00);
    ok(cen === 1'b0);
    wr(A2, 8'hFF);
    rdc(A2, asc_pkg::CTRL2_MASK);
    for (int c = 0; c < 16; c++) begin
      rs = lfsr(rs);
      wr(A1, {rs[7], 1'b0, rs[5:4], 4'(c)});
      ok(pmask === ((c < 4) ? 12'hFFF : (12'hFFF >> (c - 3))) && nref === rs[5] && pref === rs[4]);
    end
    for (int i = 0; i < 8; i++) begin
      rs = lfsr(rs);
      conv(4'(rs[15:12] % 12), 3'(i), 3'(i), rs[16], rs[17]);
    end
    sleep_m <= 1'b1;
    wr(A2, 8'h00);
    wr(A0, 8'h01);
    wr(A0, 8'h03);
    repeat (100) @(posedge clk);
    rdc(A0, 8'h03);
    wr(A0, 8'h01);
    rdc(A0, 8'h01);
    ok(dflag === 1'b0 && sh === 1'b0);
    rdc(AH, last[15:8]);
    conv(4'h5, 3'h1, 3'h3, 1'b1, 1'b0);
    sleep_m <= 1'b0;
    wr(A2, 8'h00);
    for (int s = 0; s < 2; s++) begin
      wr(A1, {1'(s), 7'h00});
      wr(A0, 8'h01);
      fire(!1'(s));
      rdc(A0, 8'h01);
      fire(1'(s));
      rdc(A0, 8'h03);
      repeat (40) @(posedge clk);
      rdc(A0, 8'h01);
    end
    wr(A2, 8'h3E);
    wr(A0, 8'h03);
    repeat (20) @(posedge clk);
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rdc(A0, 8'h00);
    ok(sh === 1'b0 && cen === 1'b0 && pmask === 12'hFFF);
    summarize();
  end
endmodule
